// ==== shared/ppc_pkg.sv ====
// Purpose: Constants and types of the per-phase power calculation block.
// Assumes: 40 MHz system clock, 24-bit signed AC samples, word-indexed registers.
// Notes: Register offsets are indices; the bus byte address is four times the index.
// Summary of operation
// - Reactive power uses a 90 degree Hilbert shift.
// - Total active power is V times I over 4.
// - Total reactive power is shifted V times I over 4.
// - Total power uses the unfiltered full-band signal.
// - Fundamental path scales samples by 1/1.175435.
// - Fundamental power computed alike from filtered samples.
// - Calibrated power is raw times (1+gain) plus offset.
// - Store algebraic, absolute and averaged 32-bit results.
// - Total algebraic and absolute powers go downstream.
// - Fundamental algebraic and absolute powers go downstream.
// - Fast clock: total refresh 80ms, settle 400ms.
// - Middle clock: total refresh 320ms, settle 1.6s.
// - Slow clock: total refresh 640ms, settle 3.2s.
// - Fast clock: fundamental refresh 80ms, settle 450ms.
// - Middle clock: fundamental refresh 320ms, settle 1.8s.
// - Slow clock: fundamental refresh 640ms, settle 3.6s.
// - Averages refresh 640ms/2.56s/5.12s, settle 1s/4s/8s.
// - Total power gains come from writable registers.
// - Total power offsets come from writable registers.
package ppc_pkg;
    localparam int SMP_W = 24;
    localparam int ADDR_W = 18;
    localparam int SYS_CLK_HZ = 40_000_000;
    localparam int UPD_FAST_MS = 80;
    localparam int UPD_MID_MS = 320;
    localparam int UPD_SLOW_MS = 640;
    localparam int UPD_FAST_CYC = int'(64'(UPD_FAST_MS) * SYS_CLK_HZ / 1000);
    localparam int UPD_MID_CYC = int'(64'(UPD_MID_MS) * SYS_CLK_HZ / 1000);
    localparam int UPD_SLOW_CYC = int'(64'(UPD_SLOW_MS) * SYS_CLK_HZ / 1000);
    localparam int AVG_FAST_MS = 640;
    localparam int AVG_PER_UPD = AVG_FAST_MS / UPD_FAST_MS;
    localparam int AVG_SHIFT = 3;
    localparam int TOT_SETTLE_MS = 400;
    localparam int FUND_SETTLE_MS = 450;
    localparam int AVG_SETTLE_MS = 1000;
    localparam int TOT_SETTLE_UPD = (TOT_SETTLE_MS + UPD_FAST_MS - 1) / UPD_FAST_MS;
    localparam int FUND_SETTLE_UPD = (FUND_SETTLE_MS + UPD_FAST_MS - 1) / UPD_FAST_MS;
    localparam int AVG_SETTLE_UPD = (AVG_SETTLE_MS + AVG_FAST_MS - 1) / AVG_FAST_MS;
    localparam logic signed [17:0] BPF_GAIN_Q16 = 18'sh0d9cb;
    localparam logic signed [16:0] HIL_C1_Q15 = 17'sh0517d;
    localparam logic signed [16:0] HIL_C3_Q15 = 17'sh01b2a;
    localparam int PWR_SHIFT = 18;
    localparam int IIR_SHIFT = 8;
    localparam logic [15:0] RES_BASE [12] = '{
        16'he805, 16'he808, 16'he80b, 16'he80e,
        16'he824, 16'he833, 16'he866, 16'he877,
        16'he8e8, 16'he8f0, 16'he900, 16'he905};
    localparam logic [15:0] COEF_BASE [4] = '{16'he959, 16'he970, 16'he98e, 16'he99c};
    localparam logic [15:0] CTRL_IDX = 16'hea00;
    localparam logic [15:0] STAT_IDX = 16'hea01;
    localparam logic [31:0] COEF_RST = 32'h0;
    localparam logic [1:0] RESP_OKAY = 2'h0;
    localparam logic [1:0] RESP_SLVERR = 2'h2;
    typedef enum logic [1:0] {MODE_FAST, MODE_MID, MODE_SLOW} ppc_mode_t;
endpackage : ppc_pkg

// ==== core/ppc_power_calc.sv ====
// Purpose: Per-phase total and fundamental active/reactive power datapath.
// Assumes: One AC sample set per phase arrives with smp_valid_i, DC already removed.
// Notes: Results are calibrated and latched at each refresh tick.
//
// The AXI4-Lite slave port was left to the implementer.
`timescale 1ns/1ps
module ppc_power_calc #(
    parameter int UPD_FAST_CYC_P = ppc_pkg::UPD_FAST_CYC,
    parameter int UPD_MID_CYC_P = ppc_pkg::UPD_MID_CYC,
    parameter int UPD_SLOW_CYC_P = ppc_pkg::UPD_SLOW_CYC
) (
    input wire logic sys_clk_i,
    input wire logic rst_b_i,
    input wire logic smp_valid_i,
    input wire logic [2:0][ppc_pkg::SMP_W-1:0] phase_voltage_sample_i,
    input wire logic [2:0][ppc_pkg::SMP_W-1:0] phase_current_sample_i,
    input wire logic [ppc_pkg::ADDR_W-1:0] s_axi_awaddr_i,
    input wire logic s_axi_awvalid_i,
    output logic s_axi_awready_o,
    input wire logic [31:0] s_axi_wdata_i,
    input wire logic [3:0] s_axi_wstrb_i,
    input wire logic s_axi_wvalid_i,
    output logic s_axi_wready_o,
    output logic [1:0] s_axi_bresp_o,
    output logic s_axi_bvalid_o,
    input wire logic s_axi_bready_i,
    input wire logic [ppc_pkg::ADDR_W-1:0] s_axi_araddr_i,
    input wire logic s_axi_arvalid_i,
    output logic s_axi_arready_o,
    output logic [31:0] s_axi_rdata_o,
    output logic [1:0] s_axi_rresp_o,
    output logic s_axi_rvalid_o,
    input wire logic s_axi_rready_i,
    output logic [2:0][31:0] tot_act_sgn_o,
    output logic [2:0][31:0] tot_react_sgn_o,
    output logic [2:0][31:0] fund_act_sgn_o,
    output logic [2:0][31:0] fund_react_sgn_o,
    output logic [2:0][31:0] tot_act_abs_o,
    output logic [2:0][31:0] tot_react_abs_o,
    output logic [2:0][31:0] fund_act_abs_o,
    output logic [2:0][31:0] fund_react_abs_o,
    output logic inst_update_o,
    output logic avg_update_o
);
    import ppc_pkg::*;

    // ---------------------------------------------------------------
    // Refresh timing
    // ---------------------------------------------------------------
    ppc_mode_t mode_reg;
    logic [31:0] tick_cnt_reg, period;
    logic inst_tick, avg_tick, mode_wr, inst_update_reg, avg_update_reg;
    logic [2:0] avg_cnt_reg;
    logic [3:0] inst_upd_cnt_reg;
    logic [1:0] avg_upd_cnt_reg;
    always_comb begin
        unique case (mode_reg)
            MODE_FAST: period = 32'(UPD_FAST_CYC_P);
            MODE_MID: period = 32'(UPD_MID_CYC_P);
            MODE_SLOW: period = 32'(UPD_SLOW_CYC_P);
            default: period = 32'(UPD_FAST_CYC_P);
        endcase
    end

    assign inst_tick = (tick_cnt_reg == period - 32'h1);
    assign avg_tick = inst_tick && (avg_cnt_reg == 3'(AVG_PER_UPD - 1));
    // A mode change restarts the refresh period so no window mixes two rates.
    always_ff @(posedge sys_clk_i) begin
        if (!rst_b_i || mode_wr || inst_tick) begin
            tick_cnt_reg <= 32'h0;
        end else begin
            tick_cnt_reg <= tick_cnt_reg + 32'h1;
        end
    end

    always_ff @(posedge sys_clk_i) begin
        if (!rst_b_i || mode_wr) begin
            avg_cnt_reg <= 3'h0;
        end else if (inst_tick) begin
            avg_cnt_reg <= avg_cnt_reg + 3'h1;
        end
    end
    // Settling is counted in refreshes, so it scales with the selected rate.
    always_ff @(posedge sys_clk_i) begin
        if (!rst_b_i || mode_wr) begin
            inst_upd_cnt_reg <= 4'h0;
            avg_upd_cnt_reg <= 2'h0;
        end else begin
            if (inst_tick && inst_upd_cnt_reg != 4'hf) begin
                inst_upd_cnt_reg <= inst_upd_cnt_reg + 4'h1;
            end
            if (avg_tick && avg_upd_cnt_reg != 2'h3) begin
                avg_upd_cnt_reg <= avg_upd_cnt_reg + 2'h1;
            end
        end
    end

    always_ff @(posedge sys_clk_i) begin
        if (!rst_b_i) begin
            inst_update_reg <= 1'b0;
            avg_update_reg <= 1'b0;
        end else begin
            inst_update_reg <= inst_tick;
            avg_update_reg <= avg_tick;
        end
    end
    assign inst_update_o = inst_update_reg;
    assign avg_update_o = avg_update_reg;

    // ---------------------------------------------------------------
    // Coefficient registers
    // ---------------------------------------------------------------
    // Groups: total gain, fundamental gain, total offset, fundamental offset.
    // Entry e = kind * 3 + phase, kind 0 active and 1 reactive.
    logic [31:0] coef_reg [4][6];
    logic wr_en;
    logic [15:0] wr_idx;
    logic [31:0] wr_mask;

    assign wr_idx = s_axi_awaddr_i[ADDR_W-1:2];
    assign wr_mask = {{8{s_axi_wstrb_i[3]}}, {8{s_axi_wstrb_i[2]}},
                      {8{s_axi_wstrb_i[1]}}, {8{s_axi_wstrb_i[0]}}};
    assign mode_wr = wr_en && (wr_idx == CTRL_IDX) && s_axi_wstrb_i[0]
                     && (s_axi_wdata_i[1:0] != 2'h3);
    for (genvar g = 0; g < 4; g++) begin : g_coef_grp
        for (genvar e = 0; e < 6; e++) begin : g_coef_ent
            always_ff @(posedge sys_clk_i) begin
                if (!rst_b_i) begin
                    coef_reg[g][e] <= COEF_RST;
                end else if (wr_en && wr_idx == COEF_BASE[g] + 16'(e)) begin
                    coef_reg[g][e] <= (coef_reg[g][e] & ~wr_mask) | (s_axi_wdata_i & wr_mask);
                end
            end
        end
    end
    // Codes outside the enum are dropped so the rate is never undefined.
    always_ff @(posedge sys_clk_i) begin
        if (!rst_b_i) begin
            mode_reg <= MODE_FAST;
        end else if (mode_wr) begin
            mode_reg <= ppc_mode_t'(s_axi_wdata_i[1:0]);
        end
    end

    // ---------------------------------------------------------------
    // Per-phase datapath
    // ---------------------------------------------------------------
    // Quantity q: 0 total active, 1 total reactive, 2 fund active, 3 fund reactive.
    logic [3:0][2:0][31:0] sgn_reg;
    logic [3:0][2:0][31:0] abs_reg;
    logic [3:0][2:0][31:0] avg_reg;

    for (genvar p = 0; p < 3; p++) begin : g_phase
        logic signed [SMP_W-1:0] v_dly_reg [7];
        logic signed [SMP_W-1:0] i_dly_reg [4];
        logic signed [SMP_W:0] hd1, hd3;
        logic signed [SMP_W+17:0] hsum, fv_w, fi_w, fq_w;
        logic signed [SMP_W-1:0] hq, vc, ic, fv, fi, fq;
        logic signed [2*SMP_W-1:0] prod [4];
        always_ff @(posedge sys_clk_i) begin
            if (!rst_b_i) begin
                v_dly_reg <= '{default: '0};
                i_dly_reg <= '{default: '0};
            end else if (smp_valid_i) begin
                v_dly_reg[0] <= phase_voltage_sample_i[p];
                i_dly_reg[0] <= phase_current_sample_i[p];
                for (int k = 1; k < 7; k++) begin
                    v_dly_reg[k] <= v_dly_reg[k-1];
                end
                for (int k = 1; k < 4; k++) begin
                    i_dly_reg[k] <= i_dly_reg[k-1];
                end
            end
        end
        // Seven-tap antisymmetric Hilbert filter centred on tap 3; the current is
        // delayed to the same centre so only the 90 degree shift separates them.
        assign hd1 = (SMP_W+1)'(v_dly_reg[2]) - (SMP_W+1)'(v_dly_reg[4]);
        assign hd3 = (SMP_W+1)'(v_dly_reg[0]) - (SMP_W+1)'(v_dly_reg[6]);
        assign hsum = (SMP_W+18)'(hd1 * HIL_C1_Q15) + (SMP_W+18)'(hd3 * HIL_C3_Q15);
        assign hq = hsum[SMP_W+14:15];
        assign vc = v_dly_reg[3];
        assign ic = i_dly_reg[3];
        // Fundamental branch gain of 1/1.175435 in Q16.
        assign fv_w = (SMP_W+18)'(vc * BPF_GAIN_Q16);
        assign fi_w = (SMP_W+18)'(ic * BPF_GAIN_Q16);
        assign fq_w = (SMP_W+18)'(hq * BPF_GAIN_Q16);
        assign fv = fv_w[SMP_W+15:16];
        assign fi = fi_w[SMP_W+15:16];
        assign fq = fq_w[SMP_W+15:16];
        assign prod[0] = vc * ic;
        assign prod[1] = hq * ic;
        assign prod[2] = fv * fi;
        assign prod[3] = fq * fi;

        for (genvar q = 0; q < 4; q++) begin : g_qty
            logic signed [31:0] raw, flt_reg, gain, offs, cal;
            logic signed [63:0] scaled;
            logic signed [33:0] cal_w;
            logic signed [34:0] acc_reg, acc_sum;
            // The shift folds in the divide by four and the result scaling.
            assign raw = 32'(prod[q] >>> PWR_SHIFT);
            // First-order smoothing removes the twice-line-frequency ripple.
            always_ff @(posedge sys_clk_i) begin
                if (!rst_b_i) begin
                    flt_reg <= 32'sh0;
                end else if (smp_valid_i) begin
                    flt_reg <= flt_reg + 32'((33'(raw) - 33'(flt_reg)) >>> IIR_SHIFT);
                end
            end

            assign gain = coef_reg[q/2][(q%2)*3+p];
            assign offs = coef_reg[2+q/2][(q%2)*3+p];
            assign scaled = 64'(flt_reg) * 64'(gain);
            // Saturation keeps a large calibration from wrapping the sign.
            assign cal_w = 34'(flt_reg) + 34'(scaled >>> 31) + 34'(offs);
            assign cal = (cal_w > 34'sh07fffffff) ? 32'sh7fffffff :
                         (cal_w < -34'sh080000000) ? -32'sh80000000 : cal_w[31:0];
            assign acc_sum = acc_reg + 35'(cal);

            always_ff @(posedge sys_clk_i) begin
                if (!rst_b_i) begin
                    sgn_reg[q][p] <= 32'h0;
                    abs_reg[q][p] <= 32'h0;
                end else if (inst_tick) begin
                    sgn_reg[q][p] <= cal;
                    abs_reg[q][p] <= (cal == -32'sh80000000) ? 32'h7fffffff :
                                     (cal < 0) ? 32'(-cal) : cal;
                end
            end

            always_ff @(posedge sys_clk_i) begin
                if (!rst_b_i || mode_wr) begin
                    acc_reg <= 35'sh0;
                end else if (avg_tick) begin
                    acc_reg <= 35'sh0;
                end else if (inst_tick) begin
                    acc_reg <= acc_sum;
                end
            end

            always_ff @(posedge sys_clk_i) begin
                if (!rst_b_i) begin
                    avg_reg[q][p] <= 32'h0;
                end else if (avg_tick) begin
                    avg_reg[q][p] <= 32'(acc_sum >>> AVG_SHIFT);
                end
            end
        end
    end
    assign tot_act_sgn_o = sgn_reg[0];
    assign tot_react_sgn_o = sgn_reg[1];
    assign fund_act_sgn_o = sgn_reg[2];
    assign fund_react_sgn_o = sgn_reg[3];
    assign tot_act_abs_o = abs_reg[0];
    assign tot_react_abs_o = abs_reg[1];
    assign fund_act_abs_o = abs_reg[2];
    assign fund_react_abs_o = abs_reg[3];

    // ---------------------------------------------------------------
    // AXI4-Lite slave
    // ---------------------------------------------------------------
    logic awready_reg, bvalid_reg, arready_reg, rvalid_reg, rd_hit, wr_hit;
    logic [1:0] bresp_reg, rresp_reg;
    logic [31:0] rdata_reg, rd_data, status;
    logic [15:0] rd_idx;
    // Address and data are taken together, so both must be offered first.
    assign wr_en = awready_reg && s_axi_awvalid_i && s_axi_wvalid_i;

    always_comb begin
        wr_hit = (wr_idx == CTRL_IDX);
        for (int g = 0; g < 4; g++) begin
            if (wr_idx >= COEF_BASE[g] && wr_idx < COEF_BASE[g] + 16'h6) begin
                wr_hit = 1'b1;
            end
        end
    end

    always_ff @(posedge sys_clk_i) begin
        if (!rst_b_i) begin
            awready_reg <= 1'b0;
            bvalid_reg <= 1'b0;
            bresp_reg <= RESP_OKAY;
        end else begin
            awready_reg <= s_axi_awvalid_i && s_axi_wvalid_i && !awready_reg && !bvalid_reg;
            if (wr_en) begin
                bvalid_reg <= 1'b1;
                bresp_reg <= wr_hit ? RESP_OKAY : RESP_SLVERR;
            end else if (s_axi_bready_i) begin
                bvalid_reg <= 1'b0;
            end
        end
    end
    assign s_axi_awready_o = awready_reg;
    assign s_axi_wready_o = awready_reg;
    assign s_axi_bvalid_o = bvalid_reg;
    assign s_axi_bresp_o = bresp_reg;
    assign status = {29'h0,
                     avg_upd_cnt_reg >= 2'(AVG_SETTLE_UPD),
                     inst_upd_cnt_reg >= 4'(FUND_SETTLE_UPD),
                     inst_upd_cnt_reg >= 4'(TOT_SETTLE_UPD)};
    assign rd_idx = s_axi_araddr_i[ADDR_W-1:2];

    always_comb begin
        rd_data = 32'h0;
        rd_hit = 1'b0;
        if (rd_idx == CTRL_IDX) begin
            rd_data = {30'h0, mode_reg};
            rd_hit = 1'b1;
        end
        if (rd_idx == STAT_IDX) begin
            rd_data = status;
            rd_hit = 1'b1;
        end
        for (int g = 0; g < 4; g++) begin
            for (int e = 0; e < 6; e++) begin
                if (rd_idx == COEF_BASE[g] + 16'(e)) begin
                    rd_data = coef_reg[g][e];
                    rd_hit = 1'b1;
                end
            end
        end
        for (int k = 0; k < 4; k++) begin
            for (int p = 0; p < 3; p++) begin
                if (rd_idx == RES_BASE[k] + 16'(p)) begin
                    rd_data = abs_reg[k][p];
                    rd_hit = 1'b1;
                end
                if (rd_idx == RES_BASE[4+k] + 16'(p)) begin
                    rd_data = sgn_reg[k][p];
                    rd_hit = 1'b1;
                end
                if (rd_idx == RES_BASE[8+k] + 16'(p)) begin
                    rd_data = avg_reg[k][p];
                    rd_hit = 1'b1;
                end
            end
        end
    end

    always_ff @(posedge sys_clk_i) begin
        if (!rst_b_i) begin
            arready_reg <= 1'b0;
            rvalid_reg <= 1'b0;
            rdata_reg <= 32'h0;
            rresp_reg <= RESP_OKAY;
        end else begin
            arready_reg <= s_axi_arvalid_i && !arready_reg && !rvalid_reg;
            if (arready_reg && s_axi_arvalid_i) begin
                rvalid_reg <= 1'b1;
                rdata_reg <= rd_data;
                rresp_reg <= rd_hit ? RESP_OKAY : RESP_SLVERR;
            end else if (s_axi_rready_i) begin
                rvalid_reg <= 1'b0;
            end
        end
    end
    assign s_axi_arready_o = arready_reg;
    assign s_axi_rvalid_o = rvalid_reg;
    assign s_axi_rdata_o = rdata_reg;
    assign s_axi_rresp_o = rresp_reg;
endmodule : ppc_power_calc

// ==== tb/ppc_power_calc_checker.sv ====
// Purpose: Bus and result-timing properties watched at the power block's ports.
// Assumes: A single clock domain with a synchronous active-low reset.
// Notes: The refresh gap is only bounded from below, because a mode write restarts timing.
`timescale 1ns/1ps
module ppc_power_calc_checker #(
    parameter int UPD_FAST_CYC_P = 20
) (
    input wire logic sys_clk_i,
    input wire logic rst_b_i,
    input wire logic s_axi_awvalid_i,
    input wire logic s_axi_wvalid_i,
    input wire logic s_axi_awready_o,
    input wire logic s_axi_wready_o,
    input wire logic s_axi_bvalid_o,
    input wire logic s_axi_arvalid_i,
    input wire logic s_axi_arready_o,
    input wire logic s_axi_rvalid_o,
    input wire logic [2:0][31:0] tot_act_sgn_o,
    input wire logic [2:0][31:0] tot_act_abs_o,
    input wire logic [2:0][31:0] fund_react_sgn_o,
    input wire logic [2:0][31:0] fund_react_abs_o,
    input wire logic inst_update_o,
    input wire logic avg_update_o
);
    int gap_reg;
    default clocking cb @(posedge sys_clk_i); endclocking
    default disable iff (!rst_b_i);
    function automatic logic [31:0] mag(input logic [31:0] v);
        return v[31] ? ((v == 32'h80000000) ? 32'h7fffffff : -v) : v;
    endfunction : mag
    always_ff @(posedge sys_clk_i) begin
        gap_reg <= !rst_b_i ? 0 : (inst_update_o ? 1 : gap_reg + 1);
    end
    for (genvar p = 0; p < 3; p++) begin : g_ph
        chk_abs_tot: assert property (tot_act_abs_o[p] == mag(tot_act_sgn_o[p]))
            else $error("total absolute power wrong");
        chk_abs_fund: assert property (fund_react_abs_o[p] == mag(fund_react_sgn_o[p]))
            else $error("fundamental absolute power wrong");
    end
    chk_hold_out: assert property (!inst_update_o |-> $stable({tot_act_sgn_o, fund_react_sgn_o}))
        else $error("result moved without refresh");
    chk_avg_inst: assert property (avg_update_o |-> inst_update_o)
        else $error("average refresh off the instant refresh");
    chk_inst_gap: assert property (inst_update_o |-> gap_reg >= UPD_FAST_CYC_P - 1)
        else $error("refresh came too early");
    chk_aw_cause: assert property (s_axi_awready_o |-> s_axi_awvalid_i && s_axi_wvalid_i && s_axi_wready_o)
        else $error("write taken without both valids");
    chk_aw_pulse: assert property (s_axi_awready_o |=> !s_axi_awready_o && s_axi_bvalid_o)
        else $error("write response late");
    chk_ar_cause: assert property (s_axi_arready_o |-> s_axi_arvalid_i ##1 s_axi_rvalid_o)
        else $error("read response late");
endmodule : ppc_power_calc_checker

bind ppc_power_calc ppc_power_calc_checker #(.UPD_FAST_CYC_P(UPD_FAST_CYC_P)) ppc_power_calc_checker_i (
    .sys_clk_i(sys_clk_i), .rst_b_i(rst_b_i), .s_axi_awvalid_i(s_axi_awvalid_i),
    .s_axi_wvalid_i(s_axi_wvalid_i), .s_axi_awready_o(s_axi_awready_o),
    .s_axi_wready_o(s_axi_wready_o), .s_axi_bvalid_o(s_axi_bvalid_o),
    .s_axi_arvalid_i(s_axi_arvalid_i), .s_axi_arready_o(s_axi_arready_o),
    .s_axi_rvalid_o(s_axi_rvalid_o), .tot_act_sgn_o(tot_act_sgn_o), .tot_act_abs_o(tot_act_abs_o),
    .fund_react_sgn_o(fund_react_sgn_o), .fund_react_abs_o(fund_react_abs_o),
    .inst_update_o(inst_update_o), .avg_update_o(avg_update_o));

// ==== tb/ppc_smp_src.sv ====
// Purpose: Sample source standing in for the upstream filter stages.
// Assumes: One sample set per cycle while run_i is high.
// Notes: Outside samples the data lines carry the inverse, so stale values cannot pass.
`timescale 1ns/1ps
module ppc_smp_src (
    input wire logic sys_clk_i,
    input wire logic rst_b_i,
    input wire logic run_i,
    input wire logic [2:0][ppc_pkg::SMP_W-1:0] volt_set_i,
    input wire logic [2:0][ppc_pkg::SMP_W-1:0] curr_set_i,
    output logic smp_valid_o,
    output logic [2:0][ppc_pkg::SMP_W-1:0] volt_o,
    output logic [2:0][ppc_pkg::SMP_W-1:0] curr_o
);
    import ppc_pkg::*;
    always_ff @(posedge sys_clk_i) begin
        smp_valid_o <= rst_b_i && run_i;
        volt_o <= (rst_b_i && run_i) ? volt_set_i : ~volt_set_i;
        curr_o <= (rst_b_i && run_i) ? curr_set_i : ~curr_set_i;
    end
endmodule : ppc_smp_src

// ==== tb/tb.sv ====
// Purpose: Self-checking bench of the per-phase power block.
// Assumes: Short refresh periods of 20, 80 and 160 cycles.
// Notes: Power results are judged within a band, since the smoothing filter truncates.
`timescale 1ns/1ps
`define CHK(g, e) begin cmp_count++; if ((g) !== (e)) begin num_errors++; \
    $display("[ERR] %0t got %0h exp %0h", $time, g, e); end end
module tb;
    import ppc_pkg::*;
    localparam int PF = 20, PM = 80, PS = 160, FUND = 189732;
    logic sys_clk_i = 0, rst_b_i = 0, run = 0, smp_valid;
    logic [2:0][SMP_W-1:0] vset = '0, iset = '0, volt, curr;
    logic [ADDR_W-1:0] awaddr = '0, araddr = '0;
    logic awvalid = 0, wvalid = 0, bready = 0, arvalid = 0, rready = 0;
    logic [31:0] wdata = '0, rdata;
    logic awready, wready, bvalid, arready, rvalid, inst_upd, avg_upd;
    logic [1:0] bresp, rresp;
    logic [2:0][31:0] tas, trs, fas, frs, taa, tra, faa, fra;
    int num_errors = 0, cmp_count = 0, cyc = 0;
    always #12.5 sys_clk_i = ~sys_clk_i;
    ppc_smp_src ppc_smp_src_i (.sys_clk_i(sys_clk_i), .rst_b_i(rst_b_i), .run_i(run),
        .volt_set_i(vset), .curr_set_i(iset), .smp_valid_o(smp_valid), .volt_o(volt),
        .curr_o(curr));
    ppc_power_calc #(.UPD_FAST_CYC_P(PF), .UPD_MID_CYC_P(PM), .UPD_SLOW_CYC_P(PS)) ppc_power_calc_i (
        .sys_clk_i(sys_clk_i), .rst_b_i(rst_b_i), .smp_valid_i(smp_valid),
        .phase_voltage_sample_i(volt), .phase_current_sample_i(curr),
        .s_axi_awaddr_i(awaddr), .s_axi_awvalid_i(awvalid), .s_axi_awready_o(awready),
        .s_axi_wdata_i(wdata), .s_axi_wstrb_i(4'hf), .s_axi_wvalid_i(wvalid),
        .s_axi_wready_o(wready), .s_axi_bresp_o(bresp), .s_axi_bvalid_o(bvalid),
        .s_axi_bready_i(bready), .s_axi_araddr_i(araddr), .s_axi_arvalid_i(arvalid),
        .s_axi_arready_o(arready), .s_axi_rdata_o(rdata), .s_axi_rresp_o(rresp),
        .s_axi_rvalid_o(rvalid), .s_axi_rready_i(rready), .tot_act_sgn_o(tas),
        .tot_react_sgn_o(trs), .fund_act_sgn_o(fas), .fund_react_sgn_o(frs),
        .tot_act_abs_o(taa), .tot_react_abs_o(tra), .fund_act_abs_o(faa),
        .fund_react_abs_o(fra), .inst_update_o(inst_upd), .avg_update_o(avg_upd));
    // ----------------------------------------------------------------
    // Bus cycles and helpers
    // ----------------------------------------------------------------
    task automatic wr(input logic [15:0] idx, input logic [31:0] d, input logic [1:0] er);
        @(posedge sys_clk_i);
        awaddr <= {idx, 2'b00};
        wdata <= d;
        awvalid <= 1'b1;
        wvalid <= 1'b1;
        bready <= 1'b1;
        do @(posedge sys_clk_i); while (awready !== 1'b1);
        awvalid <= 1'b0;
        wvalid <= 1'b0;
        do @(posedge sys_clk_i); while (bvalid !== 1'b1);
        bready <= 1'b0;
        `CHK(bresp, er)
    endtask : wr
    task automatic rd(input logic [15:0] idx, output logic [31:0] d, output logic [1:0] r);
        @(posedge sys_clk_i);
        araddr <= {idx, 2'b00};
        arvalid <= 1'b1;
        rready <= 1'b1;
        do @(posedge sys_clk_i); while (arready !== 1'b1);
        arvalid <= 1'b0;
        do @(posedge sys_clk_i); while (rvalid !== 1'b1);
        rready <= 1'b0;
        d = rdata;
        r = rresp;
    endtask : rd
    // A band of 1024 covers the truncation left by the smoothing filter and the gain.
    function automatic logic near(input logic [31:0] g, input int e);
        if ((^g) === 1'bx) return 1'bx;
        return ($signed(g) - e < 1024) && (e - $signed(g) < 1024);
    endfunction : near
    task automatic gap(input bit use_avg, output int n);
        do @(posedge sys_clk_i); while ((use_avg ? avg_upd : inst_upd) !== 1'b1);
        n = 1;
        @(posedge sys_clk_i);
        while ((use_avg ? avg_upd : inst_upd) !== 1'b1) begin
            @(posedge sys_clk_i);
            n++;
        end
    endtask : gap
    task automatic t_regs;
        logic [31:0] d;
        logic [1:0] r;
        rd(COEF_BASE[0], d, r);
        `CHK(d, COEF_RST)
        rd(16'h0000, d, r);
        `CHK(r, RESP_SLVERR)
        wr(RES_BASE[4], 32'h00001234, RESP_SLVERR);
        wr(COEF_BASE[2], 32'h000003e8, RESP_OKAY);
        wr(COEF_BASE[0] + 16'h0001, 32'h40000000, RESP_OKAY);
        rd(COEF_BASE[0] + 16'h0001, d, r);
        `CHK(d, 32'h40000000)
        $display("t_regs done");
    endtask : t_regs
    task automatic t_power;
        logic [31:0] d;
        logic [1:0] r;
        vset <= {3{24'h040000}};
        iset <= {24'hfc0000, 24'h040000, 24'h040000};
        run <= 1'b1;
        repeat (4000) @(posedge sys_clk_i);
        `CHK(near(tas[0], 263144), 1'b1)
        `CHK(near(tas[1], 393216), 1'b1)
        `CHK(near(tas[2], -262144), 1'b1)
        `CHK(near(taa[2], 262144), 1'b1)
        `CHK(near(trs[0], 0), 1'b1)
        `CHK(near(tra[1], 0), 1'b1)
        `CHK(near(fas[1], FUND), 1'b1)
        `CHK(near(faa[2], FUND), 1'b1)
        rd(RES_BASE[8] + 16'h0002, d, r);
        `CHK(near(d, -262144), 1'b1)
        rd(RES_BASE[6], d, r);
        `CHK(near(d, FUND), 1'b1)
        rd(STAT_IDX, d, r);
        `CHK(d, 32'h00000007)
        $display("t_power done");
    endtask : t_power
    task automatic t_timing;
        int n;
        int per[4] = '{PF, PM, PS, PS};
        // Mode 3 is not a valid choice, so the slow period must survive it.
        for (int m = 0; m < 4; m++) begin
            wr(CTRL_IDX, 32'(m), RESP_OKAY);
            gap(1'b0, n);
            `CHK(n, per[m])
        end
        wr(CTRL_IDX, 32'h00000000, RESP_OKAY);
        gap(1'b1, n);
        `CHK(n, 8 * PF)
        $display("t_timing done");
    endtask : t_timing
    task automatic results;
        $display("compares %0d errors %0d", cmp_count, num_errors);
        if (num_errors == 0 && cmp_count > 0) $display("Finished cleanly");
        else $display("Finished with errors");
        $finish;
    endtask : results
    always @(posedge sys_clk_i) begin
        cyc++;
        if (cyc == 20000) begin
            num_errors++;
            results();
        end
    end
    initial begin
        repeat (12) @(posedge sys_clk_i);
        rst_b_i <= 1'b1;
        t_regs();
        t_power();
        t_timing();
        results();
    end
endmodule : tb
